// >>> hw/cop_param_bank.sv
// Purpose: operator configuration parameters reached by SDO accesses
// Assumes: SDO framing decoded upstream into index, subindex and strobes
// Notes:   nonvolatile copy written through a store strobe; the values
//          loaded from it arrive on nv_* with nv_load after power-on
// Operation
// R1 - FFh selects stored process-data assignment
// R2 - source defaults FFh, applied now, stored
// R3 - 255 gives node address inverter plus one
// R4 - 1 to 127 used directly as node
// R5 - node and arm writes immediate, persisted
// R6 - zero arm value: watchdog active immediately
// R7 - bits 0-2: SYNC, guarding, OPERATIONAL
// R8 - bits 3-5: output msg 1, 2, SDO
// R9 - any selected event arms watchdog
// R10 - arming restarts on power-on and CAN reset
// R11 - out-of-range write aborts 6/9/0030h
// R12 - arm bits 6 and 7 ignored
`timescale 1ns/1ns
`include "cop_defines.svh"
module cop_param_bank
  import cop_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        can_reset,
  input  wire logic        req_wr,
  input  wire logic        req_rd,
  input  wire logic [15:0] req_index,
  input  wire logic [7:0]  req_subindex,
  input  wire logic [7:0]  req_data,
  input  wire logic        nv_load,
  input  wire logic [7:0]  nv_wdog_arm,
  input  wire logic [7:0]  nv_pd_source,
  input  wire logic [7:0]  nv_node_sel,
  input  wire logic [6:0]  inverter_address_param,
  input  wire cop_bus_ev_t bus_ev,
  output logic             ack_r,
  output logic [7:0]       rd_data_r,
  output logic             abort_r,
  output cop_abort_t       abort_code_r,
  output logic             nv_store_r,
  output logic [15:0]      nv_index_r,
  output logic [7:0]       nv_data_r,
  output logic             pd_use_stored_r,
  output logic [7:0]       node_id_r,
  output logic             wdog_active_r
);
  logic [7:0]  watchdog_arm_events_r, watchdog_arm_events_nxt;
  logic [7:0]  pd_assignment_source_r, pd_assignment_source_nxt;
  logic [7:0]  node_address_select_r, node_address_select_nxt;
  logic        ack_nxt, abort_nxt, nv_store_nxt;
  logic [7:0]  rd_data_nxt;
  cop_abort_t  abort_code_nxt;
  logic [15:0] nv_index_nxt;
  logic [7:0]  nv_data_nxt;
  logic        pd_use_stored_nxt;
  logic [7:0]  node_id_nxt;
  logic        wdog_active;
  logic        restart;
  logic [`COP_NUM_EV-1:0] ev_vec;

  // node address value accepted: 255 or 1..127
  function automatic logic node_ok(input logic [7:0] v);
    node_ok = (v == `COP_NODE_DERIVED) ||
              (v >= `COP_NODE_MIN && v <= `COP_NODE_MAX);
  endfunction : node_ok

  // known object at subindex 0
  function automatic logic obj_known(input logic [15:0] i);
    obj_known = (i == `COP_IDX_WDOG_ARM) || (i == `COP_IDX_PD_SOURCE) ||
                (i == `COP_IDX_NODE_SEL);
  endfunction : obj_known

  // request handling: reads, checked writes, aborts, persistence
  always_comb
  begin
    watchdog_arm_events_nxt  = watchdog_arm_events_r;
    pd_assignment_source_nxt = pd_assignment_source_r;
    node_address_select_nxt  = node_address_select_r;
    ack_nxt        = 1'b0;
    abort_nxt      = 1'b0;
    abort_code_nxt = abort_code_r;
    rd_data_nxt    = rd_data_r;
    nv_store_nxt   = 1'b0;
    nv_index_nxt   = nv_index_r;
    nv_data_nxt    = nv_data_r;
    if (nv_load)
    begin
      watchdog_arm_events_nxt  = nv_wdog_arm;
      pd_assignment_source_nxt = nv_pd_source;
      node_address_select_nxt  = node_ok(nv_node_sel) ? nv_node_sel
                                                       : `COP_RST_NODE_SEL;
    end
    else if ((req_wr || req_rd) &&
             (!obj_known(req_index) || req_subindex != 8'h00))
    begin
      abort_nxt      = 1'b1;
      abort_code_nxt = '{`COP_ERR_CLASS_RANGE, `COP_ERR_CODE_NOOBJ,
                         `COP_ERR_ADD_NOOBJ};
    end
    else if (req_rd)
    begin
      ack_nxt = 1'b1;
      case (req_index)
        `COP_IDX_WDOG_ARM:  rd_data_nxt = watchdog_arm_events_r;
        `COP_IDX_PD_SOURCE: rd_data_nxt = pd_assignment_source_r;
        default:            rd_data_nxt = node_address_select_r;
      endcase
    end
    else if (req_wr && req_index == `COP_IDX_NODE_SEL &&
             !node_ok(req_data))
    begin
      abort_nxt      = 1'b1; // R11
      abort_code_nxt = '{`COP_ERR_CLASS_RANGE, `COP_ERR_CODE_RANGE,
                         `COP_ERR_ADD_RANGE}; // R11
    end
    else if (req_wr)
    begin
      ack_nxt      = 1'b1;
      nv_store_nxt = 1'b1; // R2 R5
      nv_index_nxt = req_index;
      nv_data_nxt  = req_data;
      case (req_index)
        `COP_IDX_WDOG_ARM:  watchdog_arm_events_nxt  = req_data; // R5
        `COP_IDX_PD_SOURCE: pd_assignment_source_nxt = req_data; // R2
        default:            node_address_select_nxt  = req_data; // R5
      endcase
    end
  end

  // effective settings follow the next register values at once
  always_comb
  begin
    pd_use_stored_nxt =
      (pd_assignment_source_nxt == `COP_PD_ASSIGNMENT_SOURCE_CODE); // R1
    if (node_address_select_nxt == `COP_NODE_DERIVED)
      node_id_nxt = {1'b0, inverter_address_param} + `COP_NODE_INC; // R3
    else
      node_id_nxt = node_address_select_nxt; // R4
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      watchdog_arm_events_r  <= `COP_RST_WDOG_ARM; // R6
      pd_assignment_source_r <= `COP_RST_PD_SOURCE; // R2
      node_address_select_r  <= `COP_RST_NODE_SEL; // R3
      ack_r           <= 1'b0;
      abort_r         <= 1'b0;
      abort_code_r    <= '0;
      rd_data_r       <= 8'h00;
      nv_store_r      <= 1'b0;
      nv_index_r      <= 16'h0000;
      nv_data_r       <= 8'h00;
      pd_use_stored_r <= 1'b1;
      node_id_r       <= 8'h00;
      wdog_active_r   <= 1'b0;
    end
    else
    begin
      watchdog_arm_events_r  <= watchdog_arm_events_nxt;
      pd_assignment_source_r <= pd_assignment_source_nxt;
      node_address_select_r  <= node_address_select_nxt;
      ack_r           <= ack_nxt;
      abort_r         <= abort_nxt;
      abort_code_r    <= abort_code_nxt;
      rd_data_r       <= rd_data_nxt;
      nv_store_r      <= nv_store_nxt;
      nv_index_r      <= nv_index_nxt;
      nv_data_r       <= nv_data_nxt;
      pd_use_stored_r <= pd_use_stored_nxt;
      node_id_r       <= node_id_nxt;
      wdog_active_r   <= wdog_active;
    end
  end

  // event order follows the arm bit positions
  always_comb
  begin
    ev_vec = '0;
    ev_vec[`COP_EV_SYNC]   = bus_ev.sync; // R7
    ev_vec[`COP_EV_GUARD]  = bus_ev.guard; // R7
    ev_vec[`COP_EV_OPER]   = bus_ev.oper; // R7
    ev_vec[`COP_EV_FIRST_PROCESS_OUTPUT_MSG] = bus_ev.first_process_output_msg; // R8
    ev_vec[`COP_EV_SECOND_PROCESS_OUTPUT_MSG] = bus_ev.second_process_output_msg; // R8
    ev_vec[`COP_EV_SDO]    = bus_ev.sdo; // R8
  end

  assign restart = can_reset || nv_load; // R10

  cop_wdog_arm #(.NUM_EV(`COP_NUM_EV)) u_arm (
    .clk         (clk),
    .reset_n     (reset_n),
    .restart     (restart),
    .arm_sel     (watchdog_arm_events_r),
    .ev          (ev_vec),
    .wdog_active (wdog_active)
  );

  range_abort_a: assert property (@(posedge clk) disable iff (!reset_n)
    (req_wr && !nv_load && req_index == `COP_IDX_NODE_SEL &&
     req_subindex == 8'h00 && !node_ok(req_data))
    |=> abort_r && abort_code_r.add_code == `COP_ERR_ADD_RANGE &&
        node_address_select_r == $past(node_address_select_r))
    else $error("out-of-range write not refused"); // R11
  node_derive_a: assert property (@(posedge clk) disable iff (!reset_n)
    (node_address_select_nxt == `COP_NODE_DERIVED) |=>
    node_id_r == $past({1'b0, inverter_address_param}) + `COP_NODE_INC)
    else $error("derived node address wrong"); // R3
  node_direct_a: assert property (@(posedge clk) disable iff (!reset_n)
    (node_address_select_r != `COP_NODE_DERIVED && !$past(nv_load))
    |-> node_id_r == node_address_select_r)
    else $error("direct node address wrong"); // R4
  pd_select_a: assert property (@(posedge clk) disable iff (!reset_n)
    pd_use_stored_r == (pd_assignment_source_r == `COP_PD_ASSIGNMENT_SOURCE_CODE))
    else $error("process-data source mismatch"); // R1
  write_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    (req_wr && !nv_load && obj_known(req_index) && req_subindex == 8'h00
     && (req_index != `COP_IDX_NODE_SEL || node_ok(req_data)))
    |=> nv_store_r && ack_r && nv_data_r == $past(req_data))
    else $error("write not stored"); // R2 R5
  zero_active_a: assert property (@(posedge clk) disable iff (!reset_n)
    ((watchdog_arm_events_r & `COP_ARM_USED_MASK) == 8'h00) |=>
    wdog_active_r) else $error("zero setting not active"); // R6
  pd_default_a: assert property (@(posedge clk)
    !reset_n |=> pd_assignment_source_r == `COP_RST_PD_SOURCE &&
    node_address_select_r == `COP_RST_NODE_SEL)
    else $error("bad reset defaults"); // R2
endmodule : cop_param_bank

// >>> common/cop_defines.svh
// Purpose: constants for the operator configuration parameter bank
// Assumes: parameter index is the 16-bit object index, subindex 0
// Notes:   one byte per parameter
`ifndef COP_DEFINES_SVH
`define COP_DEFINES_SVH
`define COP_IDX_WDOG_ARM    16'h5FDA
`define COP_IDX_PD_SOURCE   16'h5FE2
`define COP_IDX_NODE_SEL    16'h5FE3
`define COP_RST_WDOG_ARM    8'h00
`define COP_RST_PD_SOURCE   8'hFF
`define COP_RST_NODE_SEL    8'hFF
`define COP_PD_ASSIGNMENT_SOURCE_CODE  8'hFF
`define COP_NODE_DERIVED    8'hFF
`define COP_NODE_MIN        8'h01
`define COP_NODE_MAX        8'h7F
`define COP_NODE_INC        8'h01
`define COP_ARM_USED_MASK   8'h3F
`define COP_ERR_CLASS_RANGE 8'h06
`define COP_ERR_CODE_RANGE  8'h09
`define COP_ERR_ADD_RANGE   16'h0030
`define COP_ERR_CODE_NOOBJ  8'h04
`define COP_ERR_ADD_NOOBJ   16'h0000
`define COP_EV_SYNC         0
`define COP_EV_GUARD        1
`define COP_EV_OPER         2
`define COP_EV_FIRST_PROCESS_OUTPUT_MSG       3
`define COP_EV_SECOND_PROCESS_OUTPUT_MSG       4
`define COP_EV_SDO          5
`define COP_NUM_EV          6
`endif

// >>> common/cop_pkg.sv
// Purpose: shared types of the operator configuration parameter bank
// Assumes: nothing beyond the defines header
// Notes:   abort code carries class, code and additional code
package cop_pkg;
  typedef struct packed {
    logic [7:0]  err_class;
    logic [7:0]  err_code;
    logic [15:0] add_code;
  } cop_abort_t;

  typedef struct packed {
    logic        sync;
    logic        guard;
    logic        oper;
    logic        first_process_output_msg;
    logic        second_process_output_msg;
    logic        sdo;
  } cop_bus_ev_t;
endpackage : cop_pkg

// >>> hw/cop_wdog_arm.sv
// Purpose: arms the fieldbus watchdog on the first selected bus event
// Assumes: events are one-cycle pulses on the same clock
// Notes:   restart pulse rearms the wait after power-on or CAN reset
`timescale 1ns/1ns
`include "cop_defines.svh"
module cop_wdog_arm
  import cop_pkg::*;
#(
  parameter int NUM_EV = `COP_NUM_EV
)(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              restart,
  input  wire logic [7:0]        arm_sel,
  input  wire logic [NUM_EV-1:0] ev,
  output logic                   wdog_active
);
  logic armed_r;
  logic armed_nxt;
  logic hit;

  // any selected event arms; bits 6 and 7 are masked off
  assign hit = |(ev & arm_sel[NUM_EV-1:0]); // R7 R8 R9 R12

  // zero selection means active at once; restart drops the latch
  always_comb
  begin
    armed_nxt = armed_r;
    if (restart)
      armed_nxt = 1'b0; // R10
    else if (hit)
      armed_nxt = 1'b1; // R9
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      armed_r <= 1'b0; // R10
    else
      armed_r <= armed_nxt;
  end

  assign wdog_active = armed_r ||
    ((arm_sel & `COP_ARM_USED_MASK) == 8'h00); // R6 R12

  rearm_a: assert property (@(posedge clk) disable iff (!reset_n)
    restart |=> !armed_r) else $error("restart did not rearm"); // R10
  arm_or_a: assert property (@(posedge clk) disable iff (!reset_n)
    (hit && !restart) |=> wdog_active)
    else $error("selected event did not arm"); // R9
endmodule : cop_wdog_arm

// >>> verif/cop_mst_model.sv
// Purpose: CANopen master stand-in issuing SDO jobs and bus events
// Assumes: jobs taken on the rising edge, answer within four cycles
// Notes:   released strobes drop to zero; index, subindex and data show the inverse of their last value
`timescale 1ns/1ns
module cop_mst_model
  import cop_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   ack_r,
  input  wire logic   abort_r,
  output logic        req_wr,
  output logic        req_rd,
  output logic [15:0] req_index,
  output logic [7:0]  req_subindex,
  output logic [7:0]  req_data,
  output logic        can_reset,
  output cop_bus_ev_t bus_ev
);
  // idle lines at time zero
  initial
  begin
    {req_wr, req_rd, can_reset} = 3'h0;
    {req_index, req_subindex, req_data} = 32'h0;
    bus_ev = '0;
  end

  // one job: held for one edge, then wait for ack or abort
  task automatic sdo(input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [7:0] d,
                     output logic [1:0] ok);
    @(posedge clk);
    #1;
    {req_wr, req_rd, req_index, req_subindex, req_data} = {w, !w, i, s, d};
    @(posedge clk);
    #1;
    {req_wr, req_rd} = 2'h0;
    req_index = ~i;
    req_subindex = ~s;
    req_data = ~d;
    for (int n = 0; n < 4 && !(ack_r || abort_r); n++)
      @(posedge clk) #1;
    ok = {ack_r, abort_r};
  endtask : sdo

  // one-cycle event, negative number gives a CAN reset command
  task automatic pulse(input int e);
    @(posedge clk);
    #1;
    if (e < 0)
      can_reset = 1'b1;
    else
      bus_ev = cop_bus_ev_t'(6'h20 >> e);
    @(posedge clk);
    #1;
    can_reset = 1'b0;
    bus_ev = '0;
  endtask : pulse
endmodule : cop_mst_model

// >>> verif/tb_can_operator_config_params.sv
// Purpose: self-checking bench for the operator parameter bank
// Assumes: master stand-in drives jobs one nanosecond after an edge
// Notes:   expected values come from the integer model in this file
`timescale 1ns/1ns
`include "cop_defines.svh"
module tb_can_operator_config_params
  import cop_pkg::*;
;
  logic        clk = 0, reset_n = 0, nv_load = 0;
  logic [1:0]  ok;
  logic [7:0]  nv_wdog_arm = 0, nv_pd_source = 0, nv_node_sel = 0;
  logic [7:0]  lf = 8'h26, rd_data_r, nv_data_r, node_id_r, req_data;
  logic [6:0]  inverter_address_param = 7'h7F;
  logic [15:0] req_index, nv_index_r;
  logic [7:0]  req_subindex, tbl[7];
  logic        req_wr, req_rd, can_reset, ack_r, abort_r, nv_store_r;
  logic        pd_use_stored_r, wdog_active_r;
  cop_bus_ev_t bus_ev;
  cop_abort_t  abort_code_r;
  int          n_mismatch = 0, cmp_count = 0;
  int          m_arm = 0, m_pd = 255, m_node = 255;
  int          ev_q[$];

  // clock
  always #4 clk = ~clk;

  cop_param_bank dut_u (.clk, .reset_n, .can_reset, .req_wr, .req_rd,
    .req_index, .req_subindex, .req_data, .nv_load, .nv_wdog_arm,
    .nv_pd_source, .nv_node_sel, .inverter_address_param, .bus_ev,
    .ack_r, .rd_data_r, .abort_r, .abort_code_r, .nv_store_r,
    .nv_index_r, .nv_data_r, .pd_use_stored_r, .node_id_r, .wdog_active_r);

  cop_mst_model mst_u (.clk, .ack_r, .abort_r, .req_wr, .req_rd,
    .req_index, .req_subindex, .req_data, .can_reset, .bus_ev);

  // random byte source, eight-bit linear feedback shift register
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // expected watchdog state: zero selection or a selected event seen
  function automatic logic wexp();
    wexp = (m_arm & 'h3F) == 0;
    foreach (ev_q[j])
      if (m_arm[ev_q[j]])
        wexp = 1'b1;
  endfunction : wexp

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  task automatic wt();
    repeat (3) @(posedge clk);
    #1;
  endtask : wt

  // one bus event or CAN reset, mirrored in the event queue
  task automatic ev(input int e);
    mst_u.pulse(e);
    if (e < 0)
      ev_q.delete();
    else
      ev_q.push_back(e);
  endtask : ev

  task automatic outs();
    chk(pd_use_stored_r, m_pd == 255);
    chk(node_id_r, m_node == 255 ? {1'b0, inverter_address_param} + 8'h01
                                 : 8'(m_node));
  endtask : outs

  // one job against the model
  task automatic job(input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [7:0] d);
    logic bad, rng;
    int v;
    v = i == `COP_IDX_WDOG_ARM ? m_arm
      : i == `COP_IDX_PD_SOURCE ? m_pd : m_node;
    bad = s != 0 || !(i inside {`COP_IDX_WDOG_ARM, `COP_IDX_PD_SOURCE,
                               `COP_IDX_NODE_SEL});
    rng = !bad && w && i == `COP_IDX_NODE_SEL && d != 8'hFF &&
          !(d inside {[1:127]});
    mst_u.sdo(w, i, s, d, ok);
    chk(ok, (bad || rng) ? 2'b01 : 2'b10);
    if (bad || rng)
    begin
      chk(abort_code_r, {8'h06, bad ? 24'h040000 : 24'h090030});
      chk(nv_store_r, 0);
    end
    else if (w)
    begin
      chk({nv_store_r, nv_index_r, nv_data_r}, {1'b1, i, d});
      if (i == `COP_IDX_WDOG_ARM)
        m_arm = d;
      else if (i == `COP_IDX_PD_SOURCE)
        m_pd = d;
      else
        m_node = d;
    end
    else
      chk(rd_data_r, v);
    outs();
  endtask : job

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // main sequence
  initial
  begin
    tbl = '{8'h05, 8'h01, 8'h7F, 8'h00, 8'h80, 8'hFE, 8'hFF};
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    wt();
    chk(wdog_active_r, 1);
    for (int k = 0; k < 3; k++)
      job(0, 16'h5FDA + (k ? 16'h7 + k : 0), 0, 0);
    $display("defaults done");
    for (int k = 0; k < 5; k++)
    begin
      lf = lfsr(lf);
      job(1, `COP_IDX_PD_SOURCE, 0, k == 4 ? 8'hFF : lf);
    end
    $display("source done");
    for (int k = 0; k < 7; k++)
    begin
      job(1, `COP_IDX_NODE_SEL, 0, tbl[k]);
      job(0, `COP_IDX_NODE_SEL, 0, 0);
    end
    lf = lfsr(lf);
    inverter_address_param = lf[6:0];
    wt();
    outs();
    job(1, 16'h5FE4, 0, lf);
    job(0, `COP_IDX_PD_SOURCE, 8'h01, 0);
    $display("node done");
    for (int k = 0; k < 6; k++)
    begin
      lf = lfsr(lf);
      job(1, `COP_IDX_WDOG_ARM, 0,
          8'(1 << k) | 8'(1 << ((k + 2) % 6)) | (lf & 8'hC0));
      ev(-1);
      wt();
      chk(wdog_active_r, wexp());
      ev((k + 1) % 6);
      wt();
      chk(wdog_active_r, wexp());
      ev((k + 2) % 6);
      wt();
      chk(wdog_active_r, wexp());
    end
    job(1, `COP_IDX_WDOG_ARM, 0, 8'hC0);
    ev(-1);
    wt();
    chk(wdog_active_r, wexp());
    $display("watchdog done");
    {nv_wdog_arm, nv_pd_source, nv_node_sel, nv_load} = {24'h020010, 1'b1};
    @(posedge clk);
    #1;
    nv_load = 1'b0;
    {m_arm, m_pd, m_node} = {32'd2, 32'd0, 32'd16};
    ev_q.delete();
    wt();
    outs();
    chk(wdog_active_r, wexp());
    job(0, `COP_IDX_WDOG_ARM, 0, 0);
    $display("restore done");
    stop_test();
  end

  // hang guard
  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : tb_can_operator_config_params
